/* logic/actuator_output_ctrl.sv */
// Purpose: serial command word 0 and status word 0 of an actuator driver
// Assumes: serial pins are asynchronous and sampled by clock_in
// Notes: word 1 flags and enables arrive as plain inputs
`timescale 1ns/1ps
`default_nettype none
module actuator_output_ctrl #(
   parameter int STARTUP_CYCLES = actuator_regs_pkg::STARTUP_CYCLES
) (
   input wire logic clock_in,
   input wire logic rst_b_in,
   input wire logic spi_clk_in,
   input wire logic chip_select_low_in,
   input wire logic spi_data_in,
   input wire logic pwm_in,
   input wire logic active_mode_in,
   input wire logic temp_warning_in,
   input wire logic [7:0] over_current_in,
   input wire logic [7:0] pwm_enable_in,
   input wire logic [4:0] oc_recovery_enable_in,
   input wire logic [15:0] status_word_one_in,
   output logic spi_data_out,
   output logic spi_data_oe_b_out,
   output logic [7:0] driver_on_out,
   output logic [4:0] current_sense_select_out,
   output logic status_clear_out
);
   // ----------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------
   logic [13:0] async_bits;
   logic [13:0] meta;
   logic [13:0] sync;
   logic sclk_s;
   logic cs_s;
   logic sdi_s;
   logic pwm_s;
   logic active_s;
   logic temp_s;
   logic [7:0] oc_s;
   assign async_bits = {spi_clk_in, chip_select_low_in, spi_data_in, pwm_in,
                        active_mode_in, temp_warning_in, over_current_in};

   // two flip-flops on every serial, mode, warning and over-current pin before any logic sees it
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         meta <= actuator_regs_pkg::SYNC_RESET;
         sync <= actuator_regs_pkg::SYNC_RESET;
      end else begin
         meta <= async_bits;
         sync <= meta;
      end
   end

   // synchronised copies, in the same order as the pins
   assign {sclk_s, cs_s, sdi_s, pwm_s, active_s, temp_s, oc_s} = sync;

   // ----------------------------------------------------------------
   // edge detection
   // ----------------------------------------------------------------
   logic sclk_prev;
   logic cs_prev;
   logic active_prev;
   logic sclk_rise;
   logic sclk_fall;
   logic cs_fall;
   logic cs_rise;
   logic active_rise;

   // previous samples for edge finding
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         sclk_prev <= 1'b0;
         cs_prev <= 1'b1;
         active_prev <= 1'b0;
      end else begin
         sclk_prev <= sclk_s;
         cs_prev <= cs_s;
         active_prev <= active_s;
      end
   end

   assign sclk_rise = !cs_s && sclk_s && !sclk_prev;
   assign sclk_fall = !cs_s && !sclk_s && sclk_prev;
   assign cs_fall = !cs_s && cs_prev;
   assign cs_rise = cs_s && !cs_prev;
   assign active_rise = active_s && !active_prev;

   // ----------------------------------------------------------------
   // status words
   // ----------------------------------------------------------------
   logic [7:0] oc_flag;
   logic not_ready;
   logic no_error;
   logic [15:0] cmd;
   logic [15:0] word_zero;
   logic [15:0] word_one;
   logic [14:1] flags_one;
   // open-load flags are masked from the no-error bit when bit 14 is set; word 1 still shows them
   always_comb begin
      flags_one = status_word_one_in[14:1];
      if (cmd[actuator_regs_pkg::CMD_OL_DISABLE_BIT]) begin
         flags_one[actuator_regs_pkg::ST1_OL_MSB:actuator_regs_pkg::ST1_OL_LSB] = 8'h00;
      end
   end

   // word 0: always one, supply flags not here, warning, not ready, oc
   assign word_zero = {1'b1, 3'h0, temp_s, not_ready, 1'b0, oc_flag, no_error};
   assign no_error = ~(temp_s | not_ready | (|oc_flag) | (|flags_one));
   assign word_one = {1'b1, status_word_one_in[14:1], no_error};

   // ----------------------------------------------------------------
   // frame shifter
   // ----------------------------------------------------------------
   logic [15:0] shift_in;
   logic [15:0] shift_out;
   logic [4:0] bit_count;
   logic frame_ok;

   assign frame_ok = (bit_count == actuator_regs_pkg::FRAME_BITS);

   // count edges, saturating past a full frame so long frames fail
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         bit_count <= 5'h00;
      end else if (cs_fall) begin
         bit_count <= 5'h00;
      end else if (sclk_rise && bit_count <= actuator_regs_pkg::FRAME_BITS) begin
         bit_count <= bit_count + 5'h01;
      end
   end

   // data in sampled on rising clock, bit 0 first
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         shift_in <= 16'h0000;
      end else if (sclk_rise) begin
         shift_in <= {sdi_s, shift_in[15:1]};
      end
   end

   // first rising edge loads the word chosen by the first bit
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         shift_out <= 16'h0000;
      end else if (sclk_rise && bit_count == 5'h00) begin
         shift_out <= sdi_s ? word_one : word_zero;
      end else if (sclk_fall && bit_count != 5'h00) begin
         shift_out <= {1'b0, shift_out[15:1]};
      end
   end

   // data out: no-error level until clocked, next bit on each fall
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         spi_data_out <= 1'b0;
      end else if (!cs_s && bit_count == 5'h00) begin
         spi_data_out <= no_error;
      end else if (sclk_fall && bit_count != 5'h00) begin
         spi_data_out <= shift_out[1];
      end
   end

   // driver enabled, active low, while chip select is low
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         spi_data_oe_b_out <= 1'b1;
      end else begin
         spi_data_oe_b_out <= cs_s;
      end
   end

   // ----------------------------------------------------------------
   // command register and status clear
   // ----------------------------------------------------------------
   logic frame_to_zero;
   assign frame_to_zero = cs_rise && frame_ok && !shift_in[actuator_regs_pkg::CMD_SELECT_BIT];
   // only a complete frame addressed to word 0 updates the command
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         cmd <= actuator_regs_pkg::CMD_RESET_VALUE;
      end else if (frame_to_zero) begin
         cmd <= shift_in;
      end
   end

   // reset bit clears both status words at the end of the frame
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         status_clear_out <= 1'b0;
      end else begin
         status_clear_out <= frame_to_zero && shift_in[actuator_regs_pkg::CMD_RESET_BIT];
      end
   end

   // ----------------------------------------------------------------
   // start-up timer
   // ----------------------------------------------------------------
   logic [15:0] startup_count;
   // not-ready from entry to active mode until the timer expires
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         not_ready <= 1'b0;
         startup_count <= 16'h0000;
      end else if (active_rise) begin
         not_ready <= 1'b1;
         startup_count <= 16'h0000;
      end else if (not_ready) begin
         if (startup_count >= 16'(STARTUP_CYCLES - 1)) begin
            not_ready <= 1'b0;
         end else begin
            startup_count <= startup_count + 16'h0001;
         end
      end
   end

   // ----------------------------------------------------------------
   // over-current flags and retry
   // ----------------------------------------------------------------
   logic [7:0] oc_event;
   logic [7:0] retry_on;
   logic [7:0] allow;
   logic [7:0] req;
   logic high_duty;

   // the warning forces the lower retry duty
   assign high_duty = cmd[actuator_regs_pkg::CMD_DUTY_BIT] && !temp_s;
   assign oc_event = oc_s & driver_on_out;

   genvar gi;
   generate
      for (gi = 0; gi < actuator_regs_pkg::DRIVERS; gi++) begin : g_drv
         localparam int OUT_IDX = (gi < 6) ? gi / 2 : gi - 3;
         logic rec_en;
         assign rec_en = oc_recovery_enable_in[OUT_IDX];
         // flag set wins over a clear in the same cycle
         always_ff @(posedge clock_in or negedge rst_b_in) begin
            if (!rst_b_in) begin
               oc_flag[gi] <= 1'b0;
            end else if (oc_event[gi]) begin
               oc_flag[gi] <= 1'b1;
            end else if (status_clear_out) begin
               oc_flag[gi] <= 1'b0;
            end
         end
         oc_retry_timer u_retry (
            .clock_in(clock_in),
            .rst_b_in(rst_b_in),
            .enable_in(rec_en),
            .trip_in(oc_event[gi]),
            .clear_in(status_clear_out),
            .high_duty_in(high_duty),
            .conduct_out(retry_on[gi])
         );
         // a flagged driver runs only inside a retry window
         assign allow[gi] = !oc_flag[gi] || (rec_en && retry_on[gi]);
         // command bit, then pwm gating when enabled
         assign req[gi] = cmd[actuator_regs_pkg::CMD_DRIVER_LSB + gi] && allow[gi]
                          && (!pwm_enable_in[gi] || pwm_s);
      end
   endgenerate

   // ----------------------------------------------------------------
   // output stage
   // ----------------------------------------------------------------
   logic [7:0] next_driver_on;
   // bridge interlock and start-up blocking
   always_comb begin
      next_driver_on = req;
      for (int b = 0; b < actuator_regs_pkg::BRIDGES; b++) begin
         if (req[2 * b] && req[2 * b + 1]) begin
            next_driver_on[2 * b] = 1'b0;
            next_driver_on[2 * b + 1] = 1'b0;
         end
      end
      if (!active_s || active_rise || not_ready) begin // wake edge blocks before not-ready
         next_driver_on = 8'h00;
      end
   end

   // registered driver enables
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         driver_on_out <= 8'h00;
      end else begin
         driver_on_out <= next_driver_on;
      end
   end

   // ----------------------------------------------------------------
   // current monitor selector, image ratio SENSE_RATIO to one
   // ----------------------------------------------------------------
   logic [4:0] next_sense;
   // one-hot high-side choice for the sense pin mux
   always_comb begin
      case (cmd[actuator_regs_pkg::CMD_MON_MSB:actuator_regs_pkg::CMD_MON_LSB])
         actuator_regs_pkg::MON_OUT_ONE: next_sense = 5'h01;
         actuator_regs_pkg::MON_OUT_TWO: next_sense = 5'h02;
         actuator_regs_pkg::MON_OUT_THREE: next_sense = 5'h04;
         actuator_regs_pkg::MON_OUT_FOUR: next_sense = 5'h08;
         actuator_regs_pkg::MON_OUT_FIVE: next_sense = 5'h10;
         default: next_sense = 5'h00;
      endcase
   end

   // registered selector
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         current_sense_select_out <= 5'h00;
      end else begin
         current_sense_select_out <= next_sense;
      end
   end
endmodule
`default_nettype wire

/* logic/actuator_regs_pkg.sv */
// Purpose: shared constants of the actuator output command/status block
// Assumes: 100 MHz system clock
// Notes: bit positions are those of the 16-bit serial words
package actuator_regs_pkg;
   // ----------------------------------------------------------------
   // word and driver geometry
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 100;
   localparam int WORD_BITS = 16;
   localparam int DRIVERS = 8;
   localparam int HS_OUTS = 5;
   localparam int BRIDGES = 3;
   localparam int SYNC_BITS = 14;
   localparam logic [4:0] FRAME_BITS = 5'h10;
   localparam int SENSE_RATIO = 10000;

   // ----------------------------------------------------------------
   // command word fields
   // ----------------------------------------------------------------
   localparam int CMD_SELECT_BIT = 0;
   localparam int CMD_DRIVER_LSB = 1;
   localparam int CMD_MON_LSB = 9;
   localparam int CMD_MON_MSB = 11;
   localparam int CMD_DUTY_BIT = 13;
   localparam int CMD_OL_DISABLE_BIT = 14;
   localparam int CMD_RESET_BIT = 15;
   localparam logic [15:0] CMD_RESET_VALUE = 16'h0000;

   // ----------------------------------------------------------------
   // status word fields
   // ----------------------------------------------------------------
   localparam int ST_NO_ERROR_BIT = 0;
   localparam int ST_OC_LSB = 1;
   localparam int ST_NOT_READY_BIT = 10;
   localparam int ST_TEMP_WARN_BIT = 11;
   localparam int ST_ALWAYS_ONE_BIT = 15;
   localparam int ST1_OL_LSB = 1;
   localparam int ST1_OL_MSB = 8;

   // ----------------------------------------------------------------
   // monitor selector codes
   // ----------------------------------------------------------------
   localparam logic [2:0] MON_OUT_ONE = 3'h0;
   localparam logic [2:0] MON_OUT_TWO = 3'h1;
   localparam logic [2:0] MON_OUT_THREE = 3'h2;
   localparam logic [2:0] MON_OUT_FOUR = 3'h3;
   localparam logic [2:0] MON_OUT_FIVE = 3'h4;

   // ----------------------------------------------------------------
   // synchroniser reset pattern: chip select idles high (bit 12)
   // ----------------------------------------------------------------
   localparam logic [13:0] SYNC_RESET = 14'h1000;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int STARTUP_TIME_US = 50;
   localparam int STARTUP_CYCLES = STARTUP_TIME_US * CLK_MHZ;
   localparam int RETRY_PERIOD_US = 20;
   localparam int RETRY_PERIOD_CYCLES = RETRY_PERIOD_US * CLK_MHZ;
   localparam int RETRY_LOW_DUTY_PCT = 12;
   localparam int RETRY_HIGH_DUTY_PCT = 25;
   localparam logic [11:0] RETRY_PERIOD = 12'(RETRY_PERIOD_CYCLES);
   localparam logic [11:0] RETRY_ON_LOW = 12'(RETRY_PERIOD_CYCLES * RETRY_LOW_DUTY_PCT / 100);
   localparam logic [11:0] RETRY_ON_HIGH = 12'(RETRY_PERIOD_CYCLES * RETRY_HIGH_DUTY_PCT / 100);
endpackage

/* logic/oc_retry_timer.sv */
// Purpose: over-current retry sequencer for one driver
// Assumes: trip_in is an over-current event of a conducting driver, high while both last
// Notes: conduct_out opens a retry window of RETRY_ON_LOW or RETRY_ON_HIGH cycles, chosen by high_duty_in, each period
`timescale 1ns/1ps
`default_nettype none
module oc_retry_timer (
   input wire logic clock_in,
   input wire logic rst_b_in,
   input wire logic enable_in,
   input wire logic trip_in,
   input wire logic clear_in,
   input wire logic high_duty_in,
   output logic conduct_out
);
   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {RETRY_IDLE, RETRY_WAIT, RETRY_TRY} retry_state_e;
   retry_state_e state;
   logic [11:0] count;
   logic [11:0] on_len;
   logic [11:0] off_len;

   // on and off lengths make the pulsed current duty
   assign on_len = high_duty_in ? actuator_regs_pkg::RETRY_ON_HIGH
                                : actuator_regs_pkg::RETRY_ON_LOW;
   assign off_len = actuator_regs_pkg::RETRY_PERIOD - on_len;
   assign conduct_out = (state == RETRY_TRY);

   // idle until a trip, wait the off time, then retry for the on window
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state <= RETRY_IDLE;
         count <= 12'h000;
      end else if (!enable_in) begin
         state <= RETRY_IDLE;
         count <= 12'h000;
      end else begin
         case (state)
            RETRY_IDLE: begin
               if (trip_in) begin
                  state <= RETRY_WAIT;
                  count <= 12'h000;
               end
            end
            RETRY_WAIT: begin
               if (clear_in) begin
                  state <= RETRY_IDLE;
               end else if (count >= off_len - 12'h001) begin
                  state <= RETRY_TRY;
                  count <= 12'h000;
               end else begin
                  count <= count + 12'h001;
               end
            end
            RETRY_TRY: begin
               // trips inside the on window are blanked to form the duty
               if (count < on_len - 12'h001) begin
                  count <= count + 12'h001;
               end else if (trip_in) begin
                  state <= RETRY_WAIT;
                  count <= 12'h000;
               end else if (clear_in) begin
                  state <= RETRY_IDLE;
               end
            end
            default: begin
               state <= RETRY_IDLE;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

/* tb/actuator_output_ctrl_props.sv */
// Purpose: port assertions for the actuator output block
// Assumes: inputs change on the falling clock edge
// Notes: attached to every instance by the bind below
`timescale 1ns/1ps
`default_nettype none
module actuator_output_ctrl_props #(
   parameter int STARTUP_CYCLES = 5000
) (
   input wire logic clock_in,
   input wire logic rst_b_in,
   input wire logic chip_select_low_in,
   input wire logic pwm_in,
   input wire logic active_mode_in,
   input wire logic [7:0] over_current_in,
   input wire logic [7:0] pwm_enable_in,
   input wire logic [4:0] oc_recovery_enable_in,
   input wire logic [7:0] driver_on_out,
   input wire logic [4:0] current_sense_select_out,
   input wire logic status_clear_out
);
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (!rst_b_in);
   // ---------------------------------------------
   // driver, selector and status clear relations
   // ---------------------------------------------
   property p_bridge_exclusive;
      (driver_on_out[1:0] != 2'h3) && (driver_on_out[3:2] != 2'h3) && (driver_on_out[5:4] != 2'h3);
   endproperty
   a_bridge_exclusive: assert property (p_bridge_exclusive) else $error("bridge both on");
   property p_sense_onehot;
      $onehot0(current_sense_select_out);
   endproperty
   a_sense_onehot: assert property (p_sense_onehot) else $error("sense not one-hot");
   property p_clear_single;
      status_clear_out |=> !status_clear_out;
   endproperty
   a_clear_single: assert property (p_clear_single) else $error("clear pulse too long");
   property p_clear_after_frame;
      status_clear_out |-> $past(chip_select_low_in, 1) && $past(chip_select_low_in, 2);
   endproperty
   a_clear_after_frame: assert property (p_clear_after_frame) else $error("early clear");
   property p_standby_off;
      (!active_mode_in)[*5] |-> driver_on_out == 8'h00;
   endproperty
   a_standby_off: assert property (p_standby_off) else $error("driver on in standby");
   property p_startup_block;
      $rose(active_mode_in) |=> (driver_on_out == 8'h00)[*8];
   endproperty
   a_startup_block: assert property (p_startup_block) else $error("driver on at wake");
   property p_pwm_gate;
      (!pwm_in && $stable(pwm_enable_in))[*5] |-> (driver_on_out & pwm_enable_in) == 8'h00;
   endproperty
   a_pwm_gate: assert property (p_pwm_gate) else $error("gated driver on with pwm low");
   property p_oc_trip;
      $rose(over_current_in[6]) && driver_on_out[6] |-> ##6 !driver_on_out[6];
   endproperty
   a_oc_trip: assert property (p_oc_trip) else $error("driver kept on after trip");
   property p_retry_off;
      $fell(driver_on_out[6]) && oc_recovery_enable_in[3] |=> (!driver_on_out[6])[*8];
   endproperty
   a_retry_off: assert property (p_retry_off) else $error("retry off time too short");
endmodule
bind actuator_output_ctrl actuator_output_ctrl_props #(.STARTUP_CYCLES(STARTUP_CYCLES)) props_i (
   .clock_in(clock_in), .rst_b_in(rst_b_in), .chip_select_low_in(chip_select_low_in),
   .pwm_in(pwm_in), .active_mode_in(active_mode_in), .over_current_in(over_current_in),
   .pwm_enable_in(pwm_enable_in), .oc_recovery_enable_in(oc_recovery_enable_in),
   .driver_on_out(driver_on_out), .current_sense_select_out(current_sense_select_out),
   .status_clear_out(status_clear_out)
);
`default_nettype wire

/* tb/spi_master_model.sv */
// Purpose: serial bus master standing in for the controller
// Assumes: 160 ns serial clock, 100 MHz reference for pacing
// Notes: sclk idles low and stands still between frames
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
   input wire logic clock_in,
   input wire logic miso_in,
   output var logic sclk_out,
   output var logic cs_low_out,
   output var logic mosi_out
);
   localparam int HALF = 8;
   initial begin
      sclk_out = 1'h0;
      cs_low_out = 1'h1;
      mosi_out = 1'h0;
   end
   // ---------------------------------------------
   // frame transfer
   // ---------------------------------------------
   task automatic half_wait();
      repeat (HALF) @(negedge clock_in);
   endtask
   // n clocks, bit 0 first both ways; data changes after the falling edge
   task automatic xfer(input logic [16:0] w, input int n, output logic [16:0] r);
      r = 17'h00000;
      cs_low_out = 1'h0;
      half_wait();
      for (int i = 0; i < n; i++) begin
         mosi_out = w[i];
         half_wait();
         sclk_out = 1'h1;
         r[i] = miso_in;
         half_wait();
         sclk_out = 1'h0;
      end
      half_wait();
      cs_low_out = 1'h1;
      mosi_out = ~mosi_out; // released line does not keep its value
      half_wait();
   endtask
endmodule
`default_nettype wire

/* tb/actuator_output_ctrl_tb.sv */
// Purpose: self-checking bench of the actuator output block
// Assumes: short startup time parameter, serial clock 160 ns
// Notes: startup first, then table rows, framing, word select and fault cases
`timescale 1ns/1ps
`default_nettype none
module actuator_output_ctrl_tb;
   typedef struct packed {
      logic [15:0] word; logic [7:0] pen; logic pwm; logic [7:0] drv; logic [4:0] sel;
   } row_s;
   localparam row_s ROWS [11] = '{
      '{16'h0002, 8'h00, 1'h0, 8'h01, 5'h01}, '{16'h0204, 8'h00, 1'h0, 8'h02, 5'h02},
      '{16'h0408, 8'h00, 1'h0, 8'h04, 5'h04}, '{16'h0610, 8'h00, 1'h0, 8'h08, 5'h08},
      '{16'h0820, 8'h00, 1'h0, 8'h10, 5'h10}, '{16'h0a40, 8'h00, 1'h0, 8'h20, 5'h00},
      '{16'h0c80, 8'h00, 1'h0, 8'h40, 5'h00}, '{16'h0f00, 8'h00, 1'h0, 8'h80, 5'h00},
      '{16'h01fe, 8'h00, 1'h0, 8'hc0, 5'h01}, '{16'h0002, 8'h01, 1'h0, 8'h00, 5'h01},
      '{16'h0002, 8'h01, 1'h1, 8'h01, 5'h01}};
   localparam int PER = actuator_regs_pkg::RETRY_PERIOD_CYCLES;
   logic clock_in, rst_b_in, pwm_in, active_mode_in, temp_warning_in, oe_b, clr, so;
   logic [7:0] over_current_in, pwm_enable_in, drv;
   logic [4:0] oc_recovery_enable_in, sel;
   logic [15:0] status_word_one_in;
   logic [16:0] r;
   wire sclk, cs_low, mosi, miso;
   int error_cnt = 0;
   int n_checks = 0;
   int k, on;
   int clr_cnt = 0;
   // the line carries inverted data while the device is not driving it
   assign miso = oe_b ? ~so : so;
   spi_master_model m (.clock_in(clock_in), .miso_in(miso), .sclk_out(sclk),
      .cs_low_out(cs_low), .mosi_out(mosi));
   actuator_output_ctrl #(.STARTUP_CYCLES(400)) dut (.clock_in(clock_in), .rst_b_in(rst_b_in),
      .spi_clk_in(sclk), .chip_select_low_in(cs_low), .spi_data_in(mosi), .pwm_in(pwm_in),
      .active_mode_in(active_mode_in), .temp_warning_in(temp_warning_in),
      .over_current_in(over_current_in), .pwm_enable_in(pwm_enable_in),
      .oc_recovery_enable_in(oc_recovery_enable_in), .status_word_one_in(status_word_one_in),
      .spi_data_out(so), .spi_data_oe_b_out(oe_b), .driver_on_out(drv),
      .current_sense_select_out(sel), .status_clear_out(clr));
   initial begin
      clock_in = 1'h0;
      forever #5 clock_in = ~clock_in;
   end
   // count clear pulses so a frame check can see exactly one
   always @(posedge clock_in) if (clr === 1'h1) clr_cnt <= clr_cnt + 1;
   // ---------------------------------------------
   // compare and control tasks
   // ---------------------------------------------
   task automatic finish_test();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_cnt(input int got, input int exp);
      n_checks++;
      if (got < exp - 8 || got > exp + 8) begin
         error_cnt++;
         $display("wrong value at %0t: count %0d expected %0d", $time, got, exp);
      end
   endtask
   task automatic wait_drv(input logic v, input int lim);
      for (k = 0; k < lim && drv[6] !== v; k++) @(negedge clock_in);
      if (k >= lim) begin
         error_cnt++;
         $display("wrong value at %0t: driver wait ran out", $time);
         finish_test();
      end
   endtask
   task automatic tx(input logic [15:0] w);
      m.xfer({1'h0, w}, 16, r);
   endtask
   initial begin
      rst_b_in = 1'h0;
      {pwm_in, active_mode_in, temp_warning_in} = 3'h0;
      {over_current_in, pwm_enable_in, oc_recovery_enable_in} = 21'h000000;
      status_word_one_in = 16'h0000;
      repeat (8) @(negedge clock_in);
      chk_word({1'h0, oe_b, clr, sel, drv}, 16'h4000);
      rst_b_in = 1'h1;
      repeat (4) @(negedge clock_in);
      active_mode_in = 1'h1;
      repeat (6) @(negedge clock_in);
      tx(16'h0080);
      chk_word(r[15:0], 16'h8400);
      chk_word({8'h00, drv}, 16'h0000);
      repeat (200) @(negedge clock_in);
      tx(16'h0080);
      chk_word(r[15:0], 16'h8001);
      foreach (ROWS[i]) begin
         pwm_enable_in = ROWS[i].pen;
         pwm_in = ROWS[i].pwm;
         tx(ROWS[i].word);
         chk_word(r[15:0], 16'h8001);
         chk_word({8'h00, drv}, {8'h00, ROWS[i].drv});
         chk_word({11'h000, sel}, {11'h000, ROWS[i].sel});
      end
      m.xfer(17'h00000, 15, r);
      m.xfer(17'h10000, 17, r);
      chk_word({3'h0, sel, drv}, 16'h0101);
      {pwm_enable_in, pwm_in} = 9'h000;
      status_word_one_in = 16'h0004;
      tx(16'h0080);
      chk_word(r[15:0], 16'h8000);
      tx(16'h0001);
      chk_word(r[15:0], 16'h8004);
      chk_word({8'h00, drv}, 16'h0040);
      tx(16'h4080);
      tx(16'h0001);
      chk_word(r[15:0], 16'h8005);
      status_word_one_in = 16'h0200;
      tx(16'h0001);
      chk_word(r[15:0], 16'h8200);
      status_word_one_in = 16'h0000;
      tx(16'h0080);
      over_current_in[6] = 1'h1;
      repeat (6) @(negedge clock_in);
      over_current_in[6] = 1'h0;
      repeat (100) @(negedge clock_in);
      tx(16'h0080);
      chk_word(r[15:0], 16'h8080);
      chk_word({8'h00, drv}, 16'h0000);
      k = clr_cnt;
      tx(16'h8080);
      chk_word(16'(clr_cnt - k), 16'h0001);
      chk_word({8'h00, drv}, 16'h0040);
      tx(16'h0080);
      chk_word(r[15:0], 16'h8001);
      active_mode_in = 1'h0;
      repeat (10) @(negedge clock_in);
      chk_word({8'h00, drv}, 16'h0000);
      active_mode_in = 1'h1;
      repeat (300) @(negedge clock_in);
      chk_word({8'h00, drv}, 16'h0000);
      repeat (120) @(negedge clock_in);
      chk_word({8'h00, drv}, 16'h0040);
      oc_recovery_enable_in = 5'h08;
      for (int c = 0; c < 3; c++) begin
         temp_warning_in = (c == 2);
         on = PER * (c == 1 ? 25 : 12) / 100;
         tx(c > 0 ? 16'h2080 : 16'h0080);
         tx(16'h0080 | (c > 0 ? 16'h2000 : 16'h0000));
         chk_word(r[15:0], c == 2 ? 16'h8800 : 16'h8001);
         chk_word({8'h00, drv}, 16'h0040);
         over_current_in[6] = 1'h1;
         wait_drv(1'h0, 20);
         wait_drv(1'h1, 2500);
         chk_cnt(k, PER - on);
         wait_drv(1'h0, 800);
         chk_cnt(k, on);
         over_current_in[6] = 1'h0;
         tx(16'h8080);
      end
      finish_test();
   end
endmodule
`default_nettype wire
